// ### iasc_ctrl.sv
/*
 host control block: direct registers, indirect variable window, refresh,
 orientation and test pattern decode, standby modes and soft reset.
 assumes the serial control interface hands over whole 16-bit words and
 that the standby pin is asynchronous to clk_i.
*/
// Summary of operation
// - transfers are 16-bit address, 16-bit data
// - hardware registers reached directly by address
// - address register plus data window registers
// - write logical address, then data
// - logical address: size flag, driver, offset
// - settings apply after refresh code 0x06
// - orientation per context, driver 18
// - orientation decodes normal, mirror, flip, both
// - 0x100 at offset 0x03 enables pattern
// - pattern select decodes four patterns
// - pattern enters at pipeline input
// - soft standby entry with done status
// - pin with type bit set: shutdown
// - pin with type bit clear: retention
// - exit by clearing bit or pin
// - standby: parallel high-z, lane zero
// - clocks gated; interface off in hard
// - retention keeps state, shutdown issues reset
// - soft reset by 0x0219 then 0x0218
`timescale 1ns/1ns
`include "iasc_defines.svh"
module iasc_ctrl #(
    parameter int OFS_W = 10,
    parameter logic [15:0] CHIP_ID = 16'h5A5A // arbitrary identity value
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire iasc_pkg::iasc_req_s req_i,
    input wire logic standby_pin_i,
    output logic [15:0] rdata_o,
    output logic rd_valid_o,
    output logic wr_ack_o,
    output iasc_pkg::iasc_orient_s orient_a_o,
    output iasc_pkg::iasc_orient_s orient_b_o,
    output iasc_pkg::iasc_pattern_e pattern_o,
    output logic pattern_inject_o,
    output logic clk_run_o,
    output logic par_oe_o,
    output logic lane_zero_o,
    output logic por_o
);
    import iasc_pkg::*;

    localparam int MEM_W = 5 + OFS_W;
    localparam logic [11:0] ENTRY_CYC = 12'(`IASC_STBY_ENTRY_CYC);

    logic [15:0] clk_pad, stby_reg, rst_misc, pad_drv, stby_type, log_addr;
    logic [15:0] vmem [0:(1 << MEM_W) - 1];
    logic [15:0] live_or_a, live_or_b, live_tp_en, live_tp_sel;
    logic pin_s1, pin_s2, stby_done;
    logic [11:0] entry_cnt;
    iasc_state_e state, next_state;

    // standby pin synchroniser
    always_ff @(posedge clk_i)
    begin
        pin_s1 <= standby_pin_i;
        pin_s2 <= pin_s1;
    end

    // word decode; hard standby leaves the interface deaf
    wire hard_st = (state == IASC_HARD_RET) || (state == IASC_HARD_OFF);
    wire wr_ok = req_i.wr && !hard_st;
    wire rd_ok = req_i.rd && !hard_st;
    wire in_win = (req_i.addr >= `IASC_ADDR_WIN_FIRST) && (req_i.addr <= `IASC_ADDR_WIN_LAST);
    wire [2:0] win_idx = 3'((req_i.addr - `IASC_ADDR_WIN_FIRST) >> 1);
    wire log_byte = log_addr[`IASC_LOG_SIZE_BIT];
    wire [4:0] log_drv = log_addr[14:10];
    wire [OFS_W-1:0] log_ofs = OFS_W'(log_addr[9:0]);
    wire [MEM_W-1:0] mem_idx = {log_drv, log_ofs} + MEM_W'(win_idx);
    wire [15:0] win_wdata = log_byte ? {8'h00, req_i.wdata[7:0]} : req_i.wdata;
    wire var_wr = wr_ok && in_win;
    wire refresh = var_wr && (log_drv == `IASC_DRV_SEQ) && (win_idx == 3'h0) &&
                   (log_ofs == OFS_W'(`IASC_OFS_REFRESH)) &&
                   (win_wdata == `IASC_CMD_REFRESH);
    wire rst_wr = wr_ok && (req_i.addr == `IASC_ADDR_RST_MISC);
    wire soft_rst = rst_wr && rst_misc[`IASC_RST_BIT] && !req_i.wdata[`IASC_RST_BIT];
    wire por = (state == IASC_HARD_OFF) && !pin_s2;
    wire int_rst = sys_rst_i || soft_rst || por;

    // indirect variable store; contents count as lost after shutdown
    always_ff @(posedge clk_i)
    begin
        if (var_wr)
        begin
            vmem[mem_idx] <= win_wdata;
        end
    end

    // direct registers
    always_ff @(posedge clk_i)
    begin
        if (int_rst)
        begin
            clk_pad <= `IASC_RST_CLK_PAD;
            stby_reg <= `IASC_RST_STBY;
            rst_misc <= `IASC_RST_MISC;
            pad_drv <= `IASC_RST_PAD_DRV;
            stby_type <= `IASC_RST_STBY_TYPE;
            log_addr <= 16'h0000;
        end
        else if (wr_ok)
        begin
            if (req_i.addr == `IASC_ADDR_CLK_PAD)
                clk_pad <= req_i.wdata;
            else if (req_i.addr == `IASC_ADDR_STBY)
                stby_reg <= req_i.wdata;
            else if (req_i.addr == `IASC_ADDR_RST_MISC)
                rst_misc <= req_i.wdata;
            else if (req_i.addr == `IASC_ADDR_PAD_DRV)
                pad_drv <= req_i.wdata;
            else if (req_i.addr == `IASC_ADDR_STBY_TYPE)
                stby_type <= req_i.wdata;
            else if (req_i.addr == `IASC_ADDR_LOG_ADDR)
                log_addr <= req_i.wdata;
        end
    end

    // live copies, loaded only by the refresh command and cleared by any internal reset
    always_ff @(posedge clk_i)
    begin
        if (int_rst)
        begin
            live_or_a <= 16'h0000;
            live_or_b <= 16'h0000;
            live_tp_en <= 16'h0000;
            live_tp_sel <= 16'h0000;
        end
        else if (refresh)
        begin
            live_or_a <= vmem[{`IASC_DRV_CAM, OFS_W'(`IASC_OFS_ORIENT_A)}];
            live_or_b <= vmem[{`IASC_DRV_CAM, OFS_W'(`IASC_OFS_ORIENT_B)}];
            live_tp_en <= vmem[{`IASC_DRV_IO, OFS_W'(`IASC_OFS_TP_EN)}];
            live_tp_sel <= vmem[{`IASC_DRV_IO, OFS_W'(`IASC_OFS_TP_SEL)}];
        end
    end

    // orientation and pattern decode
    assign orient_a_o = '{flip_v: live_or_a[1], mirror_h: live_or_a[0]};
    assign orient_b_o = '{flip_v: live_or_b[1], mirror_h: live_or_b[0]};
    wire tp_on = (live_tp_en == `IASC_TP_EN_VALUE);
    wire [7:0] sel = live_tp_sel[7:0];
    wire sel_known = (sel == 8'h01) || (sel == 8'h04) || (sel == 8'h06) || (sel == 8'h0A);
    assign pattern_o = (tp_on && sel_known) ? iasc_pattern_e'(sel) : IASC_TP_OFF;
    // pattern replaces sensor data ahead of the whole processing chain
    assign pattern_inject_o = (pattern_o != IASC_TP_OFF) && (state == IASC_RUN);

    // standby mode sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            IASC_RUN:
                if (pin_s2)
                    next_state = stby_type[0] ? IASC_HARD_OFF : IASC_HARD_RET;
                else if (stby_reg[`IASC_STBY_REQ_BIT])
                    next_state = IASC_SOFT;
            IASC_SOFT:
                if (pin_s2)
                    next_state = stby_type[0] ? IASC_HARD_OFF : IASC_HARD_RET;
                else if (!stby_reg[`IASC_STBY_REQ_BIT])
                    next_state = IASC_RUN;
            IASC_HARD_RET:
                if (!pin_s2)
                    next_state = stby_reg[`IASC_STBY_REQ_BIT] ? IASC_SOFT : IASC_RUN;
            IASC_HARD_OFF:
                if (!pin_s2)
                    next_state = IASC_RUN;
            default:
                next_state = IASC_RUN;
        endcase
    end

    // state and entry completion counter
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state <= IASC_RUN;
            entry_cnt <= 12'h000;
            stby_done <= 1'b0;
        end
        else
        begin
            state <= soft_rst ? IASC_RUN : next_state;
            if (next_state == IASC_RUN || soft_rst)
            begin
                entry_cnt <= 12'h000;
                stby_done <= 1'b0;
            end
            else if (entry_cnt == ENTRY_CYC - 12'h001)
                stby_done <= 1'b1;
            else
                entry_cnt <= entry_cnt + 12'h001;
        end
    end

    // pin-side effects of standby
    assign clk_run_o = (state == IASC_RUN);
    assign par_oe_o = (state == IASC_RUN) && rst_misc[`IASC_PAR_EN_BIT];
    assign lane_zero_o = (state != IASC_RUN);
    assign por_o = por;

    // read mux; unmapped addresses read zero
    wire [15:0] stby_rd = {stby_reg[15], stby_done, stby_reg[13:0]};
    wire [15:0] rd_mux =
        (req_i.addr == `IASC_ADDR_CHIP_ID) ? CHIP_ID :
        (req_i.addr == `IASC_ADDR_CLK_PAD) ? clk_pad :
        (req_i.addr == `IASC_ADDR_STBY) ? stby_rd :
        (req_i.addr == `IASC_ADDR_RST_MISC) ? rst_misc :
        (req_i.addr == `IASC_ADDR_PAD_DRV) ? pad_drv :
        (req_i.addr == `IASC_ADDR_STBY_TYPE) ? stby_type :
        (req_i.addr == `IASC_ADDR_LOG_ADDR) ? log_addr :
        in_win ? vmem[mem_idx] : 16'h0000;

    // registered answers
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_o <= 16'h0000;
            rd_valid_o <= 1'b0;
            wr_ack_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= rd_ok;
            wr_ack_o <= wr_ok;
            if (rd_ok)
                rdata_o <= rd_mux;
        end
    end

    // checks
    chk_hard_deaf: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        hard_st && req_i.rd |=> !rd_valid_o) else $error("read answered in hard standby");
    chk_soft_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state == IASC_RUN && !pin_s2 && stby_reg[0] && !soft_rst |=> state == IASC_SOFT)
        else $error("soft standby not entered");
    chk_hard_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state == IASC_RUN && pin_s2 && stby_type[0] && !soft_rst |=> state == IASC_HARD_OFF)
        else $error("shutdown standby not entered");
    chk_hard_ret: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state == IASC_RUN && pin_s2 && !stby_type[0] && !soft_rst |=> state == IASC_HARD_RET)
        else $error("retention standby not entered");
    chk_pins_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state != IASC_RUN |-> !par_oe_o && lane_zero_o && !clk_run_o)
        else $error("outputs live in standby");
    chk_por_exit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state == IASC_HARD_OFF && !pin_s2 |-> por_o ##1 state == IASC_RUN)
        else $error("no reset on leaving shutdown");
    chk_done_time: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(stby_done) |-> entry_cnt == ENTRY_CYC - 12'h001 && state != IASC_RUN)
        else $error("standby done at wrong time");
    chk_refresh_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !refresh && !int_rst |=> $stable(live_or_a) && $stable(live_tp_sel))
        else $error("live setting changed without refresh");
    chk_soft_rst: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        soft_rst |=> stby_type == `IASC_RST_STBY_TYPE && rst_misc == `IASC_RST_MISC)
        else $error("soft reset did not restore");
    chk_pattern: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        live_tp_en != `IASC_TP_EN_VALUE |-> pattern_o == IASC_TP_OFF)
        else $error("pattern without enable");
    cov_soft: cover property (@(posedge clk_i) state == IASC_SOFT && stby_done);
    cov_ret: cover property (@(posedge clk_i) state == IASC_HARD_RET ##1 state == IASC_RUN);
    cov_off: cover property (@(posedge clk_i) por_o);
    cov_bars: cover property (@(posedge clk_i) pattern_o == IASC_TP_BARS);
endmodule : iasc_ctrl

// ### iasc_defines.svh
/*
 register offsets, field positions, reset values and timing counts
 for the indirect access and standby control block; included by its bare name
*/
`ifndef IASC_DEFINES_SVH
`define IASC_DEFINES_SVH
`define IASC_ADDR_CHIP_ID 16'h0000
`define IASC_ADDR_CLK_PAD 16'h0016
`define IASC_ADDR_STBY 16'h0018
`define IASC_ADDR_RST_MISC 16'h001A
`define IASC_ADDR_PAD_DRV 16'h001E
`define IASC_ADDR_STBY_TYPE 16'h0028
`define IASC_ADDR_LOG_ADDR 16'h098E
`define IASC_ADDR_WIN_FIRST 16'h0990
`define IASC_ADDR_WIN_LAST 16'h099E
`define IASC_STBY_REQ_BIT 0
`define IASC_STBY_DONE_BIT 14
`define IASC_RST_BIT 0
`define IASC_PAR_EN_BIT 9
`define IASC_LOG_SIZE_BIT 15
`define IASC_RST_CLK_PAD 16'h0000
`define IASC_RST_STBY 16'h0001
`define IASC_RST_MISC 16'h0000
`define IASC_RST_PAD_DRV 16'h0000
`define IASC_RST_STBY_TYPE 16'h0001
`define IASC_DRV_SEQ 5'h01
`define IASC_DRV_CAM 5'h12
`define IASC_DRV_IO 5'h18
`define IASC_OFS_REFRESH 10'h000
`define IASC_OFS_ORIENT_A 10'h00C
`define IASC_OFS_ORIENT_B 10'h054
`define IASC_OFS_TP_EN 10'h003
`define IASC_OFS_TP_SEL 10'h025
`define IASC_CMD_REFRESH 16'h0006
`define IASC_TP_EN_VALUE 16'h0100
`define IASC_CLK_PERIOD_NS 10
`define IASC_STBY_ENTRY_US 20
`define IASC_STBY_ENTRY_CYC ((`IASC_STBY_ENTRY_US * 1000 + `IASC_CLK_PERIOD_NS - 1) / `IASC_CLK_PERIOD_NS)
`endif

// ### iasc_pkg.sv
/*
 types for the indirect access and standby control block
 assumes nothing beyond the defines header
*/
package iasc_pkg;
    // one word-level request from the serial control interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } iasc_req_s;
    // decoded image orientation
    typedef struct packed {
        logic flip_v;
        logic mirror_h;
    } iasc_orient_s;
    typedef enum logic [3:0] {
        IASC_RUN = 4'h1,
        IASC_SOFT = 4'h2,
        IASC_HARD_RET = 4'h4,
        IASC_HARD_OFF = 4'h8
    } iasc_state_e;
    typedef enum logic [7:0] {
        IASC_TP_OFF = 8'h00,
        IASC_TP_WHITE = 8'h01,
        IASC_TP_RAMP = 8'h04,
        IASC_TP_BARS = 8'h06,
        IASC_TP_RANDOM = 8'h0A
    } iasc_pattern_e;
endpackage : iasc_pkg

// ### iasc_host.sv
/*
 host model on the serial control interface: word writes, reads, variables
 assumes its tasks are called from one process of the bench
*/
`timescale 1ns/1ns
module iasc_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic vld_i,
    input wire logic [15:0] rdata_i,
    output iasc_pkg::iasc_req_s req_o
);
    import iasc_pkg::*;
    initial req_o = '0;
    // one request held over its taking edge, answer sampled half a cycle later
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
        @(negedge clk_i);
        req_o = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_i);
        ok = w ? ack_i : vld_i;
        q = rdata_i;
        // released address and data show the inverse, never the old value
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic ok);
        logic [15:0] q;
        xfer(1'b1, a, d, q, ok);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] q, output logic ok);
        xfer(1'b0, a, 16'h0000, q, ok);
    endtask : rd
    // logical address first, then the data word
    task automatic var_wr(input logic [15:0] la, input logic [15:0] d);
        logic ok;
        wr(16'h098E, la, ok);
        wr(16'h0990, d, ok);
    endtask : var_wr
    // refresh code into sequencer driver 1, offset 0
    task automatic refresh();
        var_wr(16'h8400, 16'h0006);
    endtask : refresh
endmodule : iasc_host

// ### tb.sv
/*
 self-checking bench for the indirect access and standby control block
 assumes the host model drives the request port
*/
`timescale 1ns/1ns
module tb;
    import iasc_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic standby_pin_i = 1'b0;
    iasc_req_s req;
    logic [15:0] rdata;
    logic rd_valid, wr_ack, inject, clk_run, par_oe, lane_zero, por;
    iasc_orient_s orient_a, orient_b;
    iasc_pattern_e pattern;
    int err_total = 0;
    int samples_checked = 0;
    int por_seen = 0;
    logic ok;
    logic [15:0] rv;
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h0A};
    always #5 clk_i = ~clk_i;
    // counted mid-cycle, while the one-cycle pulse stands
    always @(negedge clk_i) if (por === 1'b1) por_seen++;
    iasc_ctrl u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
        .standby_pin_i(standby_pin_i), .rdata_o(rdata), .rd_valid_o(rd_valid),
        .wr_ack_o(wr_ack), .orient_a_o(orient_a), .orient_b_o(orient_b),
        .pattern_o(pattern), .pattern_inject_o(inject), .clk_run_o(clk_run),
        .par_oe_o(par_oe), .lane_zero_o(lane_zero), .por_o(por));
    iasc_host u_host (.clk_i(clk_i), .ack_i(wr_ack), .vld_i(rd_valid),
        .rdata_i(rdata), .req_o(req));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        u_host.rd(a, rv, ok);
        check({15'h0, ok}, 16'h0001);
        check(rv, exp);
    endtask : rdchk
    task automatic wrchk(input logic [15:0] a, input logic [15:0] d, input logic exp);
        u_host.wr(a, d, ok);
        check({15'h0, ok}, {15'h0, exp});
    endtask : wrchk
    // defaults, identity, unmapped read, then leave reset-time soft standby
    task automatic t_reset();
        rdchk(16'h0028, 16'h0001);
        rdchk(16'h0000, 16'h5A5A);
        rdchk(16'h3000, 16'h0000);
        check({15'h0, clk_run}, 16'h0000);
        wrchk(16'h0016, 16'h0400, 1'b1);
        wrchk(16'h001E, 16'h0777, 1'b1);
        wrchk(16'h001A, 16'h0218, 1'b1);
        rdchk(16'h0016, 16'h0400);
        wrchk(16'h0018, 16'h0000, 1'b1);
        @(negedge clk_i);
        check({15'h0, clk_run}, 16'h0001);
    endtask : t_reset
    // soft standby entry, done status, live interface, exit
    task automatic t_soft();
        wrchk(16'h001A, 16'h0218, 1'b1);
        check({15'h0, par_oe}, 16'h0001);
        wrchk(16'h0028, 16'h0000, 1'b1);
        wrchk(16'h0018, 16'h0001, 1'b1);
        @(negedge clk_i);
        check({14'h0, par_oe, lane_zero}, 16'h0001);
        check({15'h0, clk_run}, 16'h0000);
        rdchk(16'h0018, 16'h0001);
        repeat (2000) @(negedge clk_i);
        rdchk(16'h0018, 16'h4001);
        wrchk(16'h0018, 16'h0000, 1'b1);
        @(negedge clk_i);
        check({14'h0, clk_run, lane_zero}, 16'h0002);
        rdchk(16'h0018, 16'h0000);
    endtask : t_soft
    // both orientation fields through the window, applied only on refresh
    task automatic t_orient();
        for (int i = 0; i < 4; i++)
        begin
            u_host.var_wr(16'h480C, 16'(i));
            u_host.var_wr(16'h4854, 16'(3 - i));
            u_host.wr(16'h098E, 16'h480C, ok);
            rdchk(16'h0990, 16'(i));
            if (i > 0) check({14'h0, orient_a}, 16'(i - 1));
            u_host.refresh();
            check({14'h0, orient_a}, 16'(i));
            check({14'h0, orient_b}, 16'(3 - i));
        end
        u_host.var_wr(16'h8400, 16'hAB34);
        rdchk(16'h0990, 16'h0034);
    endtask : t_orient
    // every pattern code, a wrong enable value, then the ordered disable
    task automatic t_pattern();
        u_host.var_wr(16'h6003, 16'h0100);
        foreach (codes[k])
        begin
            u_host.var_wr(16'h6025, {8'h00, codes[k]});
            u_host.refresh();
            check({8'h00, pattern}, {8'h00, codes[k]});
            check({15'h0, inject}, {15'h0, codes[k] != 8'h00});
        end
        u_host.var_wr(16'h6003, 16'h0001);
        u_host.refresh();
        check({7'h0, inject, pattern}, 16'h0000);
        u_host.var_wr(16'h6025, 16'h0000);
        u_host.var_wr(16'h6003, 16'h0000);
        u_host.refresh();
        check({7'h0, inject, pattern}, 16'h0000);
    endtask : t_pattern
    // pin standby of the chosen kind; shutdown loses state and issues reset
    task automatic t_hard(input logic off);
        int p0;
        p0 = por_seen;
        wrchk(16'h001E, 16'h0777, 1'b1);
        wrchk(16'h0028, {15'h0, off}, 1'b1);
        @(negedge clk_i);
        standby_pin_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check({14'h0, clk_run, lane_zero}, 16'h0001);
        wrchk(16'h0018, 16'h0001, 1'b0);
        u_host.rd(16'h001E, rv, ok);
        check({15'h0, ok}, 16'h0000);
        standby_pin_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check(16'(por_seen - p0), {15'h0, off});
        check({15'h0, clk_run}, {15'h0, !off});
        check({14'h0, orient_a}, off ? 16'h0000 : 16'h0003);
        rdchk(16'h001E, off ? 16'h0000 : 16'h0777);
        wrchk(16'h001E, 16'h0777, 1'b1);
        wrchk(16'h0018, 16'h0000, 1'b1);
    endtask : t_hard
    // two-step soft reset clears live settings
    task automatic t_sreset();
        u_host.var_wr(16'h480C, 16'h0002);
        u_host.refresh();
        wrchk(16'h001A, 16'h0219, 1'b1);
        check({14'h0, orient_a}, 16'h0002);
        wrchk(16'h001A, 16'h0218, 1'b1);
        check({14'h0, orient_a}, 16'h0000);
        rdchk(16'h0000, 16'h5A5A);
    endtask : t_sreset
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    // main sequence
    initial
    begin
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_soft();
        t_orient();
        t_pattern();
        t_hard(1'b0);
        t_hard(1'b1);
        t_sreset();
        summarize();
    end
    // watchdog well beyond the expected run of a few thousand cycles
    initial
    begin
        #200000;
        err_total++;
        summarize();
    end
endmodule : tb
